// ===== bench/sbtc_pin_source.sv
`timescale 1ns/1ps
module sbtc_pin_source (
  input wire logic aclk,
  input wire logic go,
  input wire logic which,
  input wire logic [7:0] n_pulses,
  input wire logic [1:0] idle_lvl,
  output logic [1:0] pin,
  output logic busy
);
  localparam int HALF = 4;
  int i;
  // bursts of rising edges on one pin; the clock stands still between bursts
  initial begin
    pin = 2'b00;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'b1;
        for (i = 0; i < n_pulses; i++) begin
          pin[which] <= 1'b1;
          repeat (HALF) @(posedge aclk);
          pin[which] <= 1'b0;
          repeat (HALF) @(posedge aclk);
        end
        busy <= 1'b0;
      end else begin
        pin <= idle_lvl;
      end
    end
  end
endmodule : sbtc_pin_source

// ===== bench/test_sixteen_bit_timer_counter.sv
`timescale 1ns/1ps
`include "sbtc_regs.svh"
module test_sixteen_bit_timer_counter;
  localparam logic [11:0] A_FLAG = {`SBTC_IDX_FLAG, 2'b00};
  localparam logic [11:0] A_LO = {`SBTC_IDX_COUNT_LO, 2'b00};
  localparam logic [11:0] A_HI = {`SBTC_IDX_COUNT_HI, 2'b00};
  localparam logic [11:0] A_CTL = {`SBTC_IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_EN = {`SBTC_IDX_ENABLE, 2'b00};
  // counter-mode table: control, pin driven, asleep, pulses, expected count
  localparam logic [7:0] CFG [8] = '{8'h03, 8'h07, 8'h0b, 8'h0b, 8'h03, 8'h07, 8'h13, 8'h13};
  localparam logic [7:0] PIN = 8'b0000_0100;
  localparam logic [7:0] SLP = 8'b0011_0000;
  localparam int NP [8] = '{4, 4, 4, 4, 4, 4, 4, 2};
  localparam int EXP [8] = '{3, 3, 3, 0, 0, 3, 1, 0};
  logic aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [1:0] pin_i, pin_o, pin_oe, port_out_data, port_direction_bits, pin_read, idle_lvl;
  logic sleep, compare_unit_a, compare_unit_b, overflow_irq_req, time_base_valid;
  logic [15:0] time_base;
  logic go, which, busy;
  logic [7:0] n_pulses;
  int errors = 0;
  int samples_checked = 0;

  sbtc_top u_sbtc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .port_out_data(port_out_data),
    .port_direction_bits(port_direction_bits), .pin_read(pin_read), .sleep(sleep),
    .compare_unit_a(compare_unit_a), .compare_unit_b(compare_unit_b),
    .overflow_irq_req(overflow_irq_req), .time_base(time_base),
    .time_base_valid(time_base_valid));

  sbtc_pin_source u_sbtc_pin_source (.aclk(aclk), .go(go), .which(which),
    .n_pulses(n_pulses), .idle_lvl(idle_lvl), .pin(pin_i), .busy(busy));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // handshakes judged at the rising edge that takes them, released right after it
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic b_hit;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit) begin
      @(posedge aclk);
      b_hit = bvalid & bready;
      if (b_hit) chk("bresp", 32'(`SBTC_RESP_OKAY), 32'(bresp));
      if (awvalid & awready) awvalid <= 1'b0;
      if (wvalid & wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic r_hit;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit) begin
      @(posedge aclk);
      r_hit = rvalid & rready;
      d = rdata;
      r = rresp;
      if (arvalid & arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rresp", 32'(`SBTC_RESP_OKAY), 32'(r));
    chk(what, exp, d);
  endtask : rchk

  // cycles between two steps of the count; skips the first, possibly ragged gap
  task automatic period(output int n);
    logic [15:0] t;
    @(negedge aclk);
    t = time_base;
    while (time_base === t) @(negedge aclk);
    t = time_base;
    n = 0;
    while (time_base === t) begin
      @(negedge aclk);
      n++;
    end
  endtask : period

  task automatic burst(input logic p, input int k);
    @(posedge aclk);
    which <= p;
    n_pulses <= 8'(k);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(negedge aclk); while (busy);
  endtask : burst

  task automatic print_verdict();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // whole run is about a thousand cycles; this only cuts a hang
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    print_verdict();
  end

  initial begin
    int n;
    logic [31:0] d;
    logic [1:0] r;
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, go, which} = '0;
    {sleep, compare_unit_a, compare_unit_b} = '0;
    n_pulses = 8'h00;
    idle_lvl = 2'b11;
    port_out_data = 2'b01;
    port_direction_bits = 2'b01;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped place, reserved bits, pin steering
    rchk("control", A_CTL, 32'h0);
    rchk("flag", A_FLAG, 32'h0);
    rd(12'h004, d, r);
    chk("unmapped resp", 32'(`SBTC_RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    wr(A_CTL, 8'hf0);
    rchk("control", A_CTL, 32'h30);
    chk("pin_oe", 32'h2, 32'(pin_oe));
    chk("pin_read", 32'h3, 32'(pin_read));
    chk("pin_o", 32'h1, 32'(pin_o));
    wr(A_CTL, 8'h08);
    cyc(2);
    chk("pin_oe osc", 32'h0, 32'(pin_oe));
    chk("pin_read osc", 32'h0, 32'(pin_read));
    idle_lvl <= 2'b00;
    // count bytes power up unknown; give them a value before counting
    wr(A_LO, 8'h00);
    wr(A_HI, 8'h00);
    // timer mode at each prescale, sync bit set but of no effect
    for (int ps = 0; ps < 4; ps++) begin
      wr(A_CTL, 8'(ps << 4) | 8'h05);
      period(n);
      chk("timer period", 32'(`SBTC_INST_DIV << ps), 32'(n));
      chk("time base valid", 32'h1, 32'(time_base_valid));
    end
    // stopped counter holds; a reset leaves the count alone
    wr(A_CTL, 8'h30);
    wr(A_LO, 8'h34);
    wr(A_HI, 8'h12);
    cyc(20);
    rchk("frozen low", A_LO, 32'h34);
    rchk("frozen high", A_HI, 32'h12);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    rchk("count kept", A_HI, 32'h12);
    rchk("control cleared", A_CTL, 32'h0);
    // trigger from each compare unit clears the count, flag untouched
    for (int u = 0; u < 2; u++) begin
      wr(A_LO, 8'h55);
      wr(A_HI, 8'haa);
      @(posedge aclk);
      {compare_unit_b, compare_unit_a} <= 2'(1 << u);
      @(posedge aclk);
      {compare_unit_b, compare_unit_a} <= 2'b00;
      rchk("trig low", A_LO, 32'h0);
      rchk("trig high", A_HI, 32'h0);
      rchk("trig flag", A_FLAG, 32'h0);
    end
    // trigger in the cycle a count write lands: the write wins
    fork
      wr(A_LO, 8'h66);
      begin
        @(posedge aclk iff (awvalid && awready && wvalid && wready));
        compare_unit_a <= 1'b1;
        @(posedge aclk);
        compare_unit_a <= 1'b0;
      end
    join
    rchk("write beats trig", A_LO, 32'h66);
    // asynchronous counter mode leaves the trigger unhonoured
    wr(A_CTL, 8'h06);
    @(posedge aclk);
    compare_unit_b <= 1'b1;
    @(posedge aclk);
    compare_unit_b <= 1'b0;
    rchk("async trig", A_LO, 32'h66);
    // wrap from all ones, flag and gated request
    wr(A_LO, 8'hfe);
    wr(A_HI, 8'hff);
    wr(A_CTL, 8'h01);
    n = 0;
    do begin
      rd(A_FLAG, d, r);
      n++;
    end while (d[0] !== 1'b1 && n < 20);
    chk("overflow flag", 32'h1, d);
    chk("irq masked", 32'h0, 32'(overflow_irq_req));
    wr(A_CTL, 8'h00);
    rchk("wrapped high", A_HI, 32'h0);
    wr(A_EN, 8'h01);
    chk("irq raised", 32'h1, 32'(overflow_irq_req));
    rchk("enable", A_EN, 32'h1);
    wr(A_FLAG, 8'h00);
    chk("irq cleared", 32'h0, 32'(overflow_irq_req));
    // counter mode table: source pin, sync, sleep, prescale, first edge
    for (int e = 0; e < 8; e++) begin
      wr(A_CTL, 8'h00);
      wr(A_LO, 8'h00);
      wr(A_HI, 8'h00);
      sleep <= SLP[e];
      wr(A_CTL, CFG[e]);
      cyc(8);
      if (!SLP[e]) chk("tb valid", 32'(!CFG[e][2]), 32'(time_base_valid));
      burst(PIN[e], NP[e]);
      cyc(4);
      sleep <= 1'b0;
      wr(A_CTL, 8'h00);
      rchk("edges", A_LO, 32'(EXP[e]));
    end
    print_verdict();
  end
endmodule : test_sixteen_bit_timer_counter

// ===== hw/sbtc_prescaler.sv
`timescale 1ns/1ps
`include "sbtc_regs.svh"
module sbtc_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  sbtc_presc_if.presc ps
);

  logic [2:0] cnt;
  logic [2:0] mask;

  // ratio 00 passes every edge, 11 every eighth
  always_comb begin
    case (ps.ratio)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  // counts on as a ripple divider would; a clear wins over an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 3'h0;
    end else if (ps.clear) begin
      cnt <= 3'h0;
    end else if (ps.pulse) begin
      cnt <= cnt + 3'h1;
    end
  end

  assign ps.tick = ps.pulse && !ps.clear && ((cnt & mask) == mask);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  clear_empties_a: assert property (ps.clear |=> cnt == 3'h0)
    else $error("prescaler not cleared after count write");
  div_eight_a: assert property (ps.tick && ps.ratio == 2'h3 |-> cnt == 3'h7)
    else $error("1:8 prescale ticked early");

endmodule : sbtc_prescaler

// ===== hw/sbtc_top.sv
`timescale 1ns/1ps
`include "sbtc_regs.svh"
// Functional notes
// - sixteen-bit count of two bytes, counts up from 0000 to ffff, wraps to zero.
// - wrap sets overflow flag bit 0; interrupt request only while enable bit set.
// - source select set picks external pin rising edges, clear picks instruction clock.
// - timer mode steps once per instruction cycle and ignores the sync control bit.
// - on bit set lets the count advance; clear freezes it holding its value.
// - prescale field 00,01,10,11 divides input by 1,2,4,8.
// - oscillator enable makes both oscillator pins inputs reading zero, ignoring direction.
// - counter mode uses crystal input pin if oscillator enabled, else external clock pin.
// - once enabled in counter mode, a falling edge must come before any counted rise.
// - sync mode synchronises after the prescaler; prescaler itself is a ripple divider.
// - synchronised counter mode in sleep stops the count; prescaler still counts.
// - sync bypass set counts unsynchronised, runs in sleep, overflow may wake.
// - asynchronous counter mode offers no time base to capture or compare.
// - count byte reads while running externally return a clean byte.
// - compare special event trigger clears the count, making compare pair the period.
// - trigger clearing of the count never sets the overflow flag.
// - trigger clearing holds only in timer or synchronised counter mode.
// - a count write in the same cycle as a trigger wins; trigger dropped.
// - control bits seven and six are unimplemented and read zero.
// - any write to either count byte clears the prescaler.
// - control clears to zero on power-on reset; other resets leave it.
// - no reset alters the count bytes; only the trigger clears them.
module sbtc_top #(
  parameter int ADDR_W = 12,
  parameter int INST_DIV = `SBTC_INST_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] pin_i,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe,
  input wire logic [1:0] port_out_data,
  input wire logic [1:0] port_direction_bits,
  output logic [1:0] pin_read,
  input wire logic sleep,
  input wire logic compare_unit_a,
  input wire logic compare_unit_b,
  output logic overflow_irq_req,
  output logic [15:0] time_base,
  output logic time_base_valid
);

  // timer state
  logic [7:0] timer_one_control;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [1:0] div_cnt;
  logic inst_tick;
  logic sel_prev;
  logic armed;
  logic sync_tick;

  // bus state
  sbtc_pkg::sbtc_wr_state_t wr_state;
  sbtc_pkg::sbtc_rd_state_t rd_state;
  logic aw_got;
  logic w_got;
  logic [9:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane;

  // control field views
  logic counter_on;
  logic clock_source_select;
  logic sync_bypass;
  logic crystal_osc_enable;
  sbtc_pkg::sbtc_ratio_t input_prescale_field;
  assign counter_on = timer_one_control[`SBTC_CTL_ON];
  assign clock_source_select = timer_one_control[`SBTC_CTL_CS];
  assign sync_bypass = timer_one_control[`SBTC_CTL_SYNC];
  assign crystal_osc_enable = timer_one_control[`SBTC_CTL_OSC];
  assign input_prescale_field = timer_one_control[`SBTC_CTL_PS_HI:`SBTC_CTL_PS_LO];

  logic [15:0] count;
  assign count = {count_high_byte, count_low_byte};

  logic async_mode;
  assign async_mode = clock_source_select && sync_bypass;

  // decoded write strobes, valid in the single cycle the write lands
  logic do_write;
  logic wr_ctl;
  logic wr_lo;
  logic wr_hi;
  logic wr_flag;
  logic wr_en;
  logic wr_hit;
  assign do_write = aw_got && w_got && wr_state == sbtc_pkg::SBTC_WR_IDLE;
  always_comb begin
    wr_ctl = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_flag = 1'b0;
    wr_en = 1'b0;
    wr_hit = 1'b1;
    if (wr_idx == `SBTC_IDX_CONTROL) begin
      wr_ctl = do_write && wr_lane;
    end else if (wr_idx == `SBTC_IDX_COUNT_LO) begin
      wr_lo = do_write && wr_lane;
    end else if (wr_idx == `SBTC_IDX_COUNT_HI) begin
      wr_hi = do_write && wr_lane;
    end else if (wr_idx == `SBTC_IDX_FLAG) begin
      wr_flag = do_write && wr_lane;
    end else if (wr_idx == `SBTC_IDX_ENABLE) begin
      wr_en = do_write && wr_lane;
    end else begin
      wr_hit = 1'b0;
    end
  end

  logic count_wr;
  assign count_wr = wr_lo || wr_hi;

  // instruction clock enable, one pulse every INST_DIV bus clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 2'h0;
    end else if (div_cnt == 2'(INST_DIV - 1)) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end
  assign inst_tick = div_cnt == 2'(INST_DIV - 1);

  // source pin: crystal input when the oscillator runs, else clock pin
  logic sel_pin;
  assign sel_pin = crystal_osc_enable ? pin_i[1] : pin_i[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_prev <= 1'b0;
    end else begin
      sel_prev <= sel_pin;
    end
  end

  logic sel_rise;
  logic sel_fall;
  assign sel_rise = sel_pin && !sel_prev;
  assign sel_fall = !sel_pin && sel_prev;

  // a rise is only trusted after a fall seen while enabled in counter mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 1'b0;
    end else if (!counter_on || !clock_source_select) begin
      armed <= 1'b0;
    end else if (sel_fall) begin
      armed <= 1'b1;
    end
  end

  // prescaler input: instruction tick or armed pin rise
  sbtc_presc_if ps_if ();
  logic ext_edge;
  assign ext_edge = armed && sel_rise;
  assign ps_if.pulse = counter_on && (clock_source_select ? ext_edge : inst_tick);
  assign ps_if.clear = count_wr;
  assign ps_if.ratio = input_prescale_field;

  sbtc_prescaler u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .ps(ps_if.ctrl)
  );

  // synchroniser stage after the prescaler, shut off in sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_tick <= 1'b0;
    end else begin
      sync_tick <= ps_if.tick && clock_source_select && !sync_bypass && !sleep;
    end
  end

  // timer mode takes the prescaled tick directly; sync bit ignored there
  logic inc;
  always_comb begin
    if (!clock_source_select) begin
      inc = ps_if.tick;
    end else if (sync_bypass) begin
      inc = ps_if.tick;
    end else begin
      inc = sync_tick && counter_on;
    end
  end

  // trigger only honoured when the count lives in the bus clock domain
  logic trig;
  logic trig_take;
  assign trig = compare_unit_a || compare_unit_b;
  assign trig_take = trig && !async_mode && !count_wr;

  // count bytes: write, then trigger, then increment; never reset
  always_ff @(posedge aclk) begin
    if (count_wr) begin
      if (wr_lo) begin
        count_low_byte <= wr_byte;
      end
      if (wr_hi) begin
        count_high_byte <= wr_byte;
      end
    end else if (trig_take) begin
      count_low_byte <= 8'h00;
      count_high_byte <= 8'h00;
    end else if (inc) begin
      {count_high_byte, count_low_byte} <= count + 16'h0001;
    end
  end

  logic wrap;
  assign wrap = inc && !count_wr && !trig_take && count == `SBTC_COUNT_MAX;

  // overflow flag; the hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (wr_flag) begin
      overflow_flag <= wr_byte[`SBTC_OVF_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_irq_enable <= 1'b0;
    end else if (wr_en) begin
      overflow_irq_enable <= wr_byte[`SBTC_OVF_BIT];
    end
  end

  // in async mode this also serves as the sleep wake request
  assign overflow_irq_req = overflow_flag && overflow_irq_enable;

  // control register; aresetn stands for power-on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_one_control <= `SBTC_CTL_RESET;
    end else if (wr_ctl) begin
      timer_one_control <= wr_byte & `SBTC_CTL_IMPL_MASK;
    end
  end

  // time base withheld in asynchronous counter mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_base <= 16'h0000;
      time_base_valid <= 1'b0;
    end else begin
      time_base <= count;
      time_base_valid <= !async_mode;
    end
  end

  // pins: the oscillator forces both to input and reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o <= 2'h0;
      pin_oe <= 2'h0;
      pin_read <= 2'h0;
    end else begin
      pin_o <= port_out_data;
      pin_oe <= crystal_osc_enable ? 2'h0 : ~port_direction_bits;
      pin_read <= crystal_osc_enable ? 2'h0 : pin_i;
    end
  end

  // write channels taken in either order, one write outstanding
  assign s_axi_awready = !aw_got && wr_state == sbtc_pkg::SBTC_WR_IDLE;
  assign s_axi_wready = !w_got && wr_state == sbtc_pkg::SBTC_WR_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      wr_idx <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got <= 1'b1;
      wr_idx <= s_axi_awaddr[11:2];
    end else if (do_write) begin
      aw_got <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got <= 1'b1;
      wr_byte <= s_axi_wdata[7:0];
      wr_lane <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_got <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= sbtc_pkg::SBTC_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBTC_RESP_OKAY;
    end else begin
      case (wr_state)
        sbtc_pkg::SBTC_WR_IDLE: begin
          if (do_write) begin
            wr_state <= sbtc_pkg::SBTC_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `SBTC_RESP_OKAY : `SBTC_RESP_SLVERR;
          end
        end
        default: begin
          if (s_axi_bready) begin
            wr_state <= sbtc_pkg::SBTC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // read mux; count is in the bus domain so each byte reads clean
  logic [9:0] rd_idx;
  logic [31:0] rd_mux;
  logic rd_hit;
  assign rd_idx = s_axi_araddr[11:2];
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (rd_idx == `SBTC_IDX_CONTROL) begin
      rd_mux = {24'h000000, timer_one_control & `SBTC_CTL_IMPL_MASK};
    end else if (rd_idx == `SBTC_IDX_COUNT_LO) begin
      rd_mux = {24'h000000, count_low_byte};
    end else if (rd_idx == `SBTC_IDX_COUNT_HI) begin
      rd_mux = {24'h000000, count_high_byte};
    end else if (rd_idx == `SBTC_IDX_FLAG) begin
      rd_mux = {31'h00000000, overflow_flag};
    end else if (rd_idx == `SBTC_IDX_ENABLE) begin
      rd_mux = {31'h00000000, overflow_irq_enable};
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready = rd_state == sbtc_pkg::SBTC_RD_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= sbtc_pkg::SBTC_RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SBTC_RESP_OKAY;
    end else begin
      case (rd_state)
        sbtc_pkg::SBTC_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state <= sbtc_pkg::SBTC_RD_DATA;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `SBTC_RESP_OKAY : `SBTC_RESP_SLVERR;
          end
        end
        default: begin
          if (s_axi_rready) begin
            rd_state <= sbtc_pkg::SBTC_RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_clean_step;
    counter_on && !count_wr && !trig_take;
  endsequence

  sequence s_timer_tick;
    !clock_source_select && input_prescale_field == 2'h0 && inst_tick;
  endsequence

  wrap_sets_flag_a: assert property (s_clean_step ##0 inc && count == 16'hffff |=>
    overflow_flag && count == 16'h0000)
    else $error("wrap did not set flag or clear count");
  flag_source_a: assert property ($rose(overflow_flag) |-> $past(wrap) || $past(wr_flag))
    else $error("overflow flag set without wrap or write");
  timer_step_a: assert property (s_clean_step ##0 s_timer_tick |=>
    count == $past(count) + 16'h0001)
    else $error("timer mode did not step on instruction tick");
  off_freeze_a: assert property (!counter_on && !count_wr && !trig_take |=> $stable(count))
    else $error("count moved while off");
  trig_clear_a: assert property (trig_take |=> count == 16'h0000 && !$rose(overflow_flag))
    else $error("trigger did not clear count cleanly");
  write_wins_a: assert property (wr_lo && trig |=> count_low_byte == $past(wr_byte))
    else $error("trigger beat a count write");
  ctl_upper_a: assert property (timer_one_control[7:6] == 2'h0)
    else $error("unimplemented control bits set");
  osc_pins_a: assert property (crystal_osc_enable && $stable(crystal_osc_enable) |=>
    pin_oe == 2'h0 && pin_read == 2'h0)
    else $error("oscillator pins not forced to input");
  sleep_hold_a: assert property (clock_source_select && !sync_bypass && sleep
    && !count_wr && !trig_take ##1 sleep && !count_wr && !trig_take |=> $stable(count))
    else $error("sync counter advanced during sleep");
  arm_first_a: assert property ($rose(counter_on) && clock_source_select |=> !armed)
    else $error("counter armed without a falling edge");
  async_base_a: assert property (async_mode |=> !time_base_valid)
    else $error("time base offered in async mode");

endmodule : sbtc_top

// ===== pkg/sbtc_pkg.sv
package sbtc_pkg;

  // read channel states, gray along idle -> data
  typedef enum logic [1:0] {
    SBTC_RD_IDLE = 2'b00,
    SBTC_RD_DATA = 2'b01
  } sbtc_rd_state_t;

  // write channel states, gray along idle -> resp
  typedef enum logic [1:0] {
    SBTC_WR_IDLE = 2'b00,
    SBTC_WR_RESP = 2'b01
  } sbtc_wr_state_t;

  typedef logic [1:0] sbtc_ratio_t;

endpackage : sbtc_pkg

// ===== pkg/sbtc_presc_if.sv
`timescale 1ns/1ps
interface sbtc_presc_if;
  logic pulse;
  logic clear;
  sbtc_pkg::sbtc_ratio_t ratio;
  logic tick;

  modport ctrl (
    output pulse,
    output clear,
    output ratio,
    input tick
  );

  modport presc (
    input pulse,
    input clear,
    input ratio,
    output tick
  );
endinterface : sbtc_presc_if

// ===== pkg/sbtc_regs.svh
`ifndef SBTC_REGS_SVH
`define SBTC_REGS_SVH

// register indices; byte address is four times the index
`define SBTC_IDX_FLAG 10'h00c
`define SBTC_IDX_COUNT_LO 10'h00e
`define SBTC_IDX_COUNT_HI 10'h00f
`define SBTC_IDX_CONTROL 10'h010
`define SBTC_IDX_ENABLE 10'h08c

// control field positions
`define SBTC_CTL_ON 0
`define SBTC_CTL_CS 1
`define SBTC_CTL_SYNC 2
`define SBTC_CTL_OSC 3
`define SBTC_CTL_PS_LO 4
`define SBTC_CTL_PS_HI 5
`define SBTC_CTL_IMPL_MASK 8'h3f
`define SBTC_CTL_RESET 8'h00

// flag and enable registers hold the overflow bit at position 0
`define SBTC_OVF_BIT 0

// count limits
`define SBTC_COUNT_MAX 16'hffff
`define SBTC_COUNT_ZERO 16'h0000

// bus answers
`define SBTC_RESP_OKAY 2'h0
`define SBTC_RESP_SLVERR 2'h2

// instruction clock is the bus clock divided by four
`define SBTC_INST_DIV 4

`endif
